// >>> pbt_prbs_tester.v
// Functional notes
// R01: Sixteen generators and sixteen checkers, one per stream
// R02: Generator pattern is the 2^15-1 sequence
// R03: Pattern starts anywhere, spans one channel to frame
// R04: Global enables at mode bits 5/4, off
// R05: Host maps pattern onto consecutive channels only
// R06: Host matches output channel count to length
// R07: Control bit1 clears count, bit0 runs checker
// R08: 8-bit start field selects first compared channel
// R09: 9-bit length field, up to 256 channels
// R10: Host keeps length between one and stream size
// R11: Error count read-only, saturates at 0xFFFF
// R12: Host sets special mode and source 10
// R13: Host waits two frames before running checker
// R14: Each checker counts mismatches in 16 bits
// R15: Host avoids bit replacement on checked streams
// R16: Polynomial x^15+x^14+1; checker self-synchronises first
// R17: Reset zeroes counts, fields, stops everything
`include "pbt_defs.vh"
`default_nettype none
module pbt_prbs_tester (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst,
    // Host register port
    input  wire [13:0]  host_addr,
    input  wire         host_wr,
    input  wire         host_rd,
    input  wire [15:0]  host_wdata,
    output reg  [15:0]  host_rdata,
    output reg          host_rdata_valid,
    // Internal frame timing
    input  wire         bit_strobe,
    input  wire [7:0]   chan_num,
    // Connection memory low fields of the current output channel
    input  wire [15:0]  conn_entry_special_mode,
    input  wire [31:0]  conn_source_control,
    // Serial input stream pins
    input  wire [15:0]  rx_stream_pin,
    // Pattern words toward the output streams
    output wire         tx_valid,
    input  wire         tx_ready,
    output wire [15:0]  tx_data,
    output wire [15:0]  tx_mask,
    // Global enables
    output wire         global_generator_enable,
    output wire         global_checker_enable
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg  [15:0]  internal_mode_register;
    reg  [15:0]  checker_run;
    reg  [15:0]  error_count_clear;
    reg  [127:0] start_channel_field;
    reg  [143:0] length_field;
    reg  [15:0]  rx_s1;
    reg  [15:0]  rx_s2;
    reg  [1:0]   strobe_d;
    reg  [7:0]   chan_d1;
    reg  [7:0]   chan_d2;
    reg  [15:0]  next_rdata;
    wire [255:0] err_flat;
    wire [15:0]  gen_bit;
    wire [15:0]  gen_sel;
    wire         buf_in_ready;
    wire         tx_step;
    wire [9:0]   rgn;
    wire [3:0]   idx;
    wire         wr_ctrl;
    wire         wr_start;
    wire         wr_len;

    assign global_checker_enable   = internal_mode_register[`PBT_MODE_RX_EN]; // [R04]
    assign global_generator_enable = internal_mode_register[`PBT_MODE_TX_EN]; // [R04]

    assign rgn      = host_addr[13:4];
    assign idx      = host_addr[3:0];
    assign wr_ctrl  = host_wr & (rgn == `PBT_RGN_CTRL);
    assign wr_start = host_wr & (rgn == `PBT_RGN_START);
    assign wr_len   = host_wr & (rgn == `PBT_RGN_LEN);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            internal_mode_register <= 16'h0000; // [R17]
            checker_run            <= 16'h0000; // [R17]
            error_count_clear      <= 16'h0000;
            start_channel_field    <= 128'h0; // [R17]
            length_field           <= 144'h0; // [R17]
        end else begin
            error_count_clear <= 16'h0000;
            if (host_wr && host_addr == `PBT_ADDR_MODE)
                internal_mode_register <= host_wdata;
            if (wr_ctrl) begin
                checker_run[idx]       <= host_wdata[`PBT_CTRL_RUN]; // [R07]
                error_count_clear[idx] <= host_wdata[`PBT_CTRL_CLR]; // [R07]
            end
            if (wr_start)
                start_channel_field[idx*8 +: 8] <= host_wdata[7:0]; // [R08]
            if (wr_len)
                length_field[idx*9 +: 9] <= host_wdata[8:0]; // [R09]
        end
    end

    // ----------------------------------------
    // Register reads, one cycle after the strobe
    // ----------------------------------------
    // Clear bit is a pulse and reads back zero; the count takes no writes
    always @* begin
        next_rdata = 16'h0000;
        if (host_addr == `PBT_ADDR_MODE) begin
            next_rdata = internal_mode_register;
        end else begin
            case (rgn)
                `PBT_RGN_CTRL:  next_rdata = {15'h0000, checker_run[idx]};
                `PBT_RGN_START: next_rdata = {8'h00, start_channel_field[idx*8 +: 8]};
                `PBT_RGN_LEN:   next_rdata = {7'h00, length_field[idx*9 +: 9]};
                `PBT_RGN_ERR:   next_rdata = err_flat[idx*16 +: 16]; // [R11]
                default:        next_rdata = 16'h0000;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            host_rdata       <= 16'h0000;
            host_rdata_valid <= 1'b0;
        end else begin
            host_rdata_valid <= host_rd;
            if (host_rd)
                host_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Input sampling
    // ----------------------------------------
    // Pins pass two flops; timing is delayed to stay aligned with them
    always @(posedge clk_sys) begin
        if (rst) begin
            rx_s1    <= 16'h0000;
            rx_s2    <= 16'h0000;
            strobe_d <= 2'b00;
            chan_d1  <= 8'h00;
            chan_d2  <= 8'h00;
        end else begin
            rx_s1    <= rx_stream_pin;
            rx_s2    <= rx_s1;
            strobe_d <= {strobe_d[0], bit_strobe};
            chan_d1  <= chan_num;
            chan_d2  <= chan_d1;
        end
    end

    // ----------------------------------------
    // Generators
    // ----------------------------------------
    // Generators only advance when the buffer can take the word
    assign tx_step = bit_strobe & buf_in_ready;

    genvar n;
    generate
        for (n = 0; n < `PBT_NSTREAM; n = n + 1) begin : g_stream // [R01]
            reg  [14:0] lfsr;
            wire        fb;
            wire [9:0]  win_end;
            wire        in_win;

            // Pattern only where the entry asks for it
            assign gen_sel[n] = global_generator_enable & conn_entry_special_mode[n]
                              & (conn_source_control[2*n +: 2] == `PBT_PCC_PATTERN); // [R12] [R03]
            assign fb         = lfsr[14] ^ lfsr[13]; // [R16] [R02]
            assign gen_bit[n] = fb & gen_sel[n];

            always @(posedge clk_sys) begin
                if (rst || !global_generator_enable)
                    lfsr <= `PBT_LFSR_SEED; // [R17]
                else if (tx_step && gen_sel[n])
                    lfsr <= {lfsr[13:0], fb}; // [R02]
            end

            // Monitored window: start up to start+length-1, never wrapping
            assign win_end = {2'b00, start_channel_field[n*8 +: 8]}
                           + {1'b0, length_field[n*9 +: 9]}; // [R09]
            assign in_win  = (chan_d2 >= start_channel_field[n*8 +: 8])
                           && ({2'b00, chan_d2} < win_end); // [R08] [R05]

            pbt_checker u_checker (
                .clk_sys   (clk_sys),
                .rst       (rst),
                .active    (global_checker_enable & checker_run[n]), // [R04] [R07]
                .clear     (error_count_clear[n]), // [R07]
                .step      (strobe_d[1] & in_win),
                .rx_bit    (rx_s2[n]),
                .err_count (err_flat[n*16 +: 16]) // [R14] [R11]
            );
        end
    endgenerate

    // ----------------------------------------
    // Output buffer
    // ----------------------------------------
    pbt_buffer #(
        .WIDTH (`PBT_BUF_W)
    ) u_buffer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (bit_strobe),
        .in_ready  (buf_in_ready),
        .in_data   ({gen_sel, gen_bit}),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  ({tx_mask, tx_data})
    );
endmodule // pbt_prbs_tester
`default_nettype wire

// >>> pbt_defs.vh
`ifndef PBT_DEFS_VH
`define PBT_DEFS_VH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define PBT_NSTREAM      16
`define PBT_LFSR_W       15
`define PBT_CNT_W        16
`define PBT_BUF_W        32
// ----------------------------------------
// Register map (word addresses on the host port)
// ----------------------------------------
`define PBT_ADDR_MODE    14'h0001
`define PBT_RGN_CTRL     10'h010
`define PBT_RGN_START    10'h011
`define PBT_RGN_LEN      10'h012
`define PBT_RGN_ERR      10'h013
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define PBT_MODE_RX_EN   5
`define PBT_MODE_TX_EN   4
`define PBT_CTRL_CLR     1
`define PBT_CTRL_RUN     0
`define PBT_CNT_MAX      16'hFFFF
`define PBT_CNT_ONE      16'h0001
`define PBT_SYNC_BITS    4'hF
`define PBT_LFSR_SEED    15'h7FFF
`define PBT_PCC_PATTERN  2'b10
`endif

// >>> pbt_buffer.v
`include "pbt_defs.vh"
`default_nettype none
// Two-entry buffer; a stall at the drain side holds off the filler.
module pbt_buffer #(
    parameter WIDTH = `PBT_BUF_W
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = rd_ptr ? slot1 : slot0;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys) begin
        if (rst) begin
            slot0  <= {WIDTH{1'b0}};
            slot1  <= {WIDTH{1'b0}};
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                if (wr_ptr)
                    slot1 <= in_data;
                else
                    slot0 <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // pbt_buffer
`default_nettype wire

// >>> pbt_checker.v
`include "pbt_defs.vh"
`default_nettype none
// One stream's pattern checker with saturating error count.
module pbt_checker (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Control
    input  wire        active,
    input  wire        clear,
    // Received bit, step marks a bit inside the monitored window
    input  wire        step,
    input  wire        rx_bit,
    // Result
    output reg  [15:0] err_count
);
    reg  [14:0] shreg;
    reg  [3:0]  fill;
    wire        expected;
    wire        bump;

    assign expected = shreg[14] ^ shreg[13];
    // Compare only after the register holds 15 received bits
    assign bump = active & step & (fill == `PBT_SYNC_BITS) & (rx_bit != expected);

    always @(posedge clk_sys) begin
        if (rst) begin
            shreg <= 15'h0000;
            fill  <= 4'h0;
        end else if (!active) begin
            fill <= 4'h0;
        end else if (step) begin
            shreg <= {shreg[13:0], rx_bit};
            if (fill != `PBT_SYNC_BITS)
                fill <= fill + 4'h1;
        end
    end

    // An error in the clearing cycle is kept
    always @(posedge clk_sys) begin
        if (rst)
            err_count <= 16'h0000;
        else if (bump && clear)
            err_count <= `PBT_CNT_ONE;
        else if (bump && err_count != `PBT_CNT_MAX)
            err_count <= err_count + `PBT_CNT_ONE;
        else if (clear)
            err_count <= 16'h0000;
    end
endmodule // pbt_checker
`default_nettype wire

// >>> pbt_tester_assertions.sv
`include "pbt_defs.vh"
`default_nettype none
module pbt_tester_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Host port
    input wire logic [13:0] host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic        host_rdata_valid,
    // Pattern words and enables
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [15:0] tx_data,
    input wire logic [15:0] tx_mask,
    input wire logic        global_generator_enable,
    input wire logic        global_checker_enable
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic mode_wr = host_wr && host_addr == `PBT_ADDR_MODE;
    a_read_answer:
    assert property (host_rd |=> host_rdata_valid)
        else $error("read not answered");
    a_rdata_holds:
    assert property (!host_rd |=> $stable(host_rdata))
        else $error("read data moved without a read");
    a_gen_enable_set:
    assert property (mode_wr |=> global_generator_enable == $past(host_wdata[`PBT_MODE_TX_EN]))
        else $error("generator enable not written");
    a_chk_enable_set:
    assert property (mode_wr |=> global_checker_enable == $past(host_wdata[`PBT_MODE_RX_EN]))
        else $error("checker enable not written");
    a_enables_hold:
    assert property (!mode_wr |=> $stable(global_generator_enable) && $stable(global_checker_enable))
        else $error("enable moved without a mode write");
    a_word_held:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_mask))
        else $error("stalled word lost or changed");
    a_data_masked:
    assert property (tx_valid |-> (tx_data & ~tx_mask) == 16'h0000)
        else $error("pattern bit on unselected stream");
    a_reset_quiet:
    assert property (disable iff (1'b0) rst |=> !tx_valid && !host_rdata_valid
        && !global_generator_enable && !global_checker_enable)
        else $error("outputs active after reset");
    c_saturated: cover property (host_rdata_valid && host_rdata == `PBT_CNT_MAX);
    c_stalled: cover property (tx_valid && !tx_ready);
    c_both_on: cover property (global_generator_enable && global_checker_enable);
endmodule // pbt_tester_chk
bind pbt_prbs_tester pbt_tester_chk u_chk (.*);
`default_nettype wire

// >>> pbt_stream_sink.sv
`default_nettype none
module pbt_stream_sink (
    // Clock, reset, stall
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hold,
    // Pattern words, tally of stream 2
    input  wire logic        tx_valid,
    output wire logic        tx_ready,
    input  wire logic [15:0] tx_data,
    input  wire logic [15:0] tx_mask,
    output var  logic [15:0] n_words,
    output var  logic [15:0] n_bad
);
    timeunit 1ns / 1ps;
    logic [14:0] gen;
    wire logic fb = gen[14] ^ gen[13];
    assign tx_ready = !hold;
    always @(posedge clk_sys) begin
        if (rst) begin
            gen <= 15'h7FFF;
            n_words <= 16'h0000;
            n_bad <= 16'h0000;
        end else if (tx_valid && tx_ready && tx_mask[2]) begin
            gen <= {gen[13:0], fb};
            n_words <= n_words + 16'h0001;
            if (tx_data[2] !== fb || tx_mask !== 16'h0004) n_bad <= n_bad + 16'h0001;
        end
    end
endmodule // pbt_stream_sink
`default_nettype wire

// >>> test_per_stream_prbs_error_tester.sv
`include "pbt_defs.vh"
`default_nettype none
module test_per_stream_prbs_error_tester;
    timeunit 1ns / 1ps;
    logic        clk_sys = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, hold = 1'b0;
    logic        bit_strobe = 1'b0, host_rdata_valid, tx_valid, tx_ready;
    logic        global_generator_enable, global_checker_enable;
    logic [13:0] host_addr = 14'h0000;
    logic [7:0]  chan_num = 8'h00;
    logic [15:0] host_wdata = 16'h0000, rx_stream_pin = 16'h0000;
    logic [15:0] conn_entry_special_mode = 16'h0000, host_rdata, tx_data, tx_mask, n_words, n_bad;
    logic [31:0] conn_source_control = 32'h0000_0000;
    logic [14:0] hist, pat;
    int          failures = 0, n_compared = 0, nsync, experr;
    wire logic [15:0] en = {14'h0000, global_generator_enable, global_checker_enable};
    pbt_prbs_tester DUT (.*);
    pbt_stream_sink u_sink (.*);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] id, exp, got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED item %h expected %h seen %h", id, exp, got);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk_sys) host_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [13:0] a, input logic [15:0] exp);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk_sys) host_rd <= 1'b0;
        #1 chk({2'b00, a}, exp, host_rdata);
        @(posedge clk_sys);
    endtask
    task automatic feed(input int ch, input logic b, w);
        chan_num <= 8'(ch);
        rx_stream_pin <= {16{b}};
        bit_strobe <= 1'b1;
        if (w && nsync < 15) nsync++;
        else if (w && b != (hist[14] ^ hist[13]) && experr < 65535) experr++;
        if (w) hist = {hist[13:0], b};
        @(posedge clk_sys);
    endtask
    task automatic t_reset;
        chk(16'h00E0, 16'h0000, en);
        rd(`PBT_ADDR_MODE, 16'h0000);
        for (int k = 0; k < 4; k++) rd({`PBT_RGN_CTRL + 10'(k), 4'hF}, 16'h0000);
        rd(14'h0200, 16'h0000);
    endtask
    task automatic t_regs;
        for (int n = 0; n < 16; n++) wr({`PBT_RGN_START, 4'(n)}, {12'hFF0, 4'(n)});
        for (int n = 0; n < 16; n++) rd({`PBT_RGN_START, 4'(n)}, {12'h000, 4'(n)});
        wr({`PBT_RGN_LEN, 4'h1}, 16'hFFFF);
        rd({`PBT_RGN_LEN, 4'h1}, 16'h01FF);
        wr({`PBT_RGN_CTRL, 4'h1}, 16'h0003);
        rd({`PBT_RGN_CTRL, 4'h1}, 16'h0001);
        wr({`PBT_RGN_ERR, 4'h1}, 16'h1234);
        rd({`PBT_RGN_ERR, 4'h1}, 16'h0000);
        wr(`PBT_ADDR_MODE, 16'h0030);
        chk(16'h00E1, 16'h0003, en);
        wr(`PBT_ADDR_MODE, 16'h0020);
        chk(16'h00E2, 16'h0001, en);
    endtask
    task automatic t_rx;
        int i;
        logic b, w;
        wr({`PBT_RGN_START, 4'h3}, 16'h0005);
        wr({`PBT_RGN_LEN, 4'h3}, 16'h0002);
        wr({`PBT_RGN_CTRL, 4'h3}, 16'h0001);
        hist = 15'h0000;
        pat = 15'h7FFF;
        nsync = 0;
        experr = 0;
        // One flipped bit counts again when it reaches both taps
        for (int j = 0; j < 160; j++) begin
            i = j % 80;
            w = i >= 40 && i < 56;
            b = pat[14] ^ pat[13];
            if (w) pat = {pat[13:0], b};
            feed(i / 8, w ? b ^ (j == 55) : i[1], w);
        end
        bit_strobe <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd({`PBT_RGN_ERR, 4'h3}, 16'(experr));
    endtask
    task automatic t_sat;
        wr({`PBT_RGN_CTRL, 4'h3}, 16'h0000);
        wr({`PBT_RGN_START, 4'h3}, 16'h0000);
        wr({`PBT_RGN_LEN, 4'h3}, 16'h0100);
        wr({`PBT_RGN_CTRL, 4'h3}, 16'h0003);
        for (int j = 0; j < 65560; j++) feed(j % 256, ~(hist[14] ^ hist[13]), 1'b1);
        bit_strobe <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd({`PBT_RGN_ERR, 4'h3}, 16'hFFFF);
        wr({`PBT_RGN_ERR, 4'h3}, 16'h0000);
        rd({`PBT_RGN_ERR, 4'h3}, 16'hFFFF);
        wr({`PBT_RGN_CTRL, 4'h3}, 16'h0003);
        rd({`PBT_RGN_ERR, 4'h3}, 16'h0000);
    endtask
    task automatic t_tx;
        conn_entry_special_mode <= 16'h0004;
        conn_source_control <= 32'h0000_0020;
        hold <= 1'b1;
        wr(`PBT_ADDR_MODE, 16'h0030);
        for (int j = 0; j < 60; j++) begin
            if (j == 20) hold <= 1'b0;
            feed(j, 1'b0, 1'b0);
        end
        bit_strobe <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(16'h00E3, 16'h0000, n_bad);
        chk(16'h00E4, 16'h0001, {15'h0000, n_words > 16'd19});
    endtask
    task automatic conclude;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_regs();
        t_rx();
        t_sat();
        t_tx();
        conclude();
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        failures++;
        $display("CHECK FAILED run expected finish seen timeout");
        conclude();
    end
endmodule // test_per_stream_prbs_error_tester
`default_nettype wire
